// [tc_timer.sv]
// 8-bit timer/counter with one compare unit and an AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_timer (
    input logic CLK,
    input logic NRST,
    input logic CE,
    input logic EXT_COUNT_IN,
    input logic [`TC_ADDR_W-1:0] AWADDR,
    input logic AWVALID,
    output logic AWREADY,
    input logic [31:0] WDATA,
    input logic [3:0] WSTRB,
    input logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input logic BREADY,
    input logic [`TC_ADDR_W-1:0] ARADDR,
    input logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input logic RREADY,
    output logic COMPARE_OUT,
    output logic IRQ
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [`TC_ADDR_W-1:0] waddr_q, waddr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [7:0] rdata_q, rdata_d;
    logic wr_fire, ar_fire, rd_flag;
    logic [7:0] ctrl_q, ctrl_d, cnt_q, cnt_d, buf_q, buf_d, act_q, act_d;
    logic [7:0] flags_q, flags_d, mask_q, mask_d, ev;
    logic dir_q, dir_d, block_q, block_d, irq_q, irq_d;
    logic cnt_wr, force_cmp, tick, at_max, at_bottom, cmp_hit, ovf_hit, wrap;
    tc_pkg::tc_mode_t mode;
    tc_pkg::tc_cs_t cs;

    assign mode = tc_pkg::tc_mode_t'(ctrl_q[`TC_MODE_HI:`TC_MODE_LO]);
    assign cs = tc_pkg::tc_cs_t'(ctrl_q[`TC_CS_HI:`TC_CS_LO]);

    // ----------------------------------------------------------------
    // AXI4-Lite slave: one write and one read in flight
    // ----------------------------------------------------------------
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign ar_fire = ARVALID && arrdy_q;
    assign rd_flag = ar_fire && (ARADDR == `TC_FLAG_OFS);

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        waddr_d = waddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (AWVALID && awrdy_q) begin
            aw_have_d = 1'b1;
            waddr_d = AWADDR;
        end
        if (WVALID && wrdy_q) begin
            w_have_d = 1'b1;
            wbyte_d = WDATA[7:0];
            wlane_d = WSTRB[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            case (waddr_q)
                `TC_CTRL_OFS, `TC_COUNT_OFS, `TC_COMPARE_OFS,
                `TC_FLAG_OFS, `TC_MASK_OFS: bresp_d = `TC_RESP_OKAY;
                default: bresp_d = `TC_RESP_SLVERR;
            endcase
        end else if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        if (ar_fire) begin
            rvalid_d = 1'b1;
            rresp_d = `TC_RESP_OKAY;
            case (ARADDR)
                `TC_CTRL_OFS: rdata_d = ctrl_q & `TC_CTRL_RMASK;
                `TC_COUNT_OFS: rdata_d = cnt_q;
                `TC_COMPARE_OFS: rdata_d = buf_q;
                `TC_FLAG_OFS: rdata_d = flags_q;
                `TC_MASK_OFS: rdata_d = mask_q;
                default: begin
                    rdata_d = `TC_RST_BYTE;
                    rresp_d = `TC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && RREADY) begin
            rvalid_d = 1'b0;
        end
        // ready is offered only while the holding slot is free
        awrdy_d = !aw_have_d && !bvalid_d;
        wrdy_d = !w_have_d && !bvalid_d;
        arrdy_d = !rvalid_d;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wbyte_q <= `TC_RST_BYTE;
            wlane_q <= 1'b0;
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
            arrdy_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `TC_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= `TC_RESP_OKAY;
            rdata_q <= `TC_RST_BYTE;
        end else if (CE) begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            waddr_q <= waddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            awrdy_q <= awrdy_d;
            wrdy_q <= wrdy_d;
            arrdy_q <= arrdy_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign AWREADY = awrdy_q;
    assign WREADY = wrdy_q;
    assign ARREADY = arrdy_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign RVALID = rvalid_q;
    assign RRESP = rresp_q;
    assign RDATA = {24'h000000, rdata_q};

    // ----------------------------------------------------------------
    // clock select and waveform generator
    // ----------------------------------------------------------------
    tc_clksel u_clksel (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .cs(cs),
        .ext_pin(EXT_COUNT_IN),
        .tick(tick)
    );

    tc_wavegen u_wavegen (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .mode(mode),
        .out_mode(ctrl_q[`TC_OUT_HI:`TC_OUT_LO]),
        .match(cmp_hit),
        .wrap(wrap),
        .dir_up(dir_q),
        .force_cmp(force_cmp),
        .oc_q(COMPARE_OUT)
    );

    // ----------------------------------------------------------------
    // counter, compare unit, flags
    // ----------------------------------------------------------------
    assign cnt_wr = wr_fire && wlane_q && (waddr_q == `TC_COUNT_OFS);
    assign force_cmp = wr_fire && wlane_q && (waddr_q == `TC_CTRL_OFS)
        && wbyte_q[`TC_FORCE_BIT]
        && (mode == tc_pkg::TC_NORMAL || mode == tc_pkg::TC_CTC);
    assign at_max = (cnt_q == `TC_MAX);
    assign at_bottom = (cnt_q == `TC_BOTTOM);
    // match in the tick after equality, unless a count write blocks it
    assign cmp_hit = tick && (cnt_q == act_q) && !block_q;
    assign wrap = tick && at_max && !cnt_wr && mode == tc_pkg::TC_FAST_PWM;
    assign ovf_hit = tick && !cnt_wr && ((mode == tc_pkg::TC_PHASE_PWM)
        ? (at_bottom && !dir_q) : at_max);

    always_comb begin
        ctrl_d = ctrl_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        buf_d = buf_q;
        act_d = act_q;
        mask_d = mask_q;
        block_d = block_q;
        if (tick) begin
            block_d = 1'b0;
        end
        if (tick) begin
            case (mode)
                tc_pkg::TC_NORMAL, tc_pkg::TC_FAST_PWM: begin
                    cnt_d = cnt_q + 8'h01;
                    dir_d = 1'b1;
                end
                tc_pkg::TC_CTC: begin
                    cnt_d = (cnt_q == act_q) ? `TC_BOTTOM : cnt_q + 8'h01;
                    dir_d = 1'b1;
                end
                tc_pkg::TC_PHASE_PWM: begin
                    if (dir_q ? at_max : !at_bottom) begin
                        cnt_d = cnt_q - 8'h01;
                        dir_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                        dir_d = 1'b1;
                    end
                end
                default: cnt_d = cnt_q;
            endcase
            // pwm modes load the active compare at top to avoid odd pulses
            if (at_max && (mode == tc_pkg::TC_FAST_PWM || mode == tc_pkg::TC_PHASE_PWM)) begin
                act_d = buf_q;
            end
        end
        if (wr_fire && wlane_q) begin
            case (waddr_q)
                `TC_CTRL_OFS: ctrl_d = wbyte_q & `TC_CTRL_RMASK;
                `TC_COUNT_OFS: begin
                    cnt_d = wbyte_q;
                    block_d = 1'b1;
                end
                `TC_COMPARE_OFS: begin
                    buf_d = wbyte_q;
                    if (mode == tc_pkg::TC_NORMAL || mode == tc_pkg::TC_CTC) begin
                        act_d = wbyte_q;
                    end
                end
                `TC_MASK_OFS: mask_d = wbyte_q & `TC_FLG_MASK;
                default: ctrl_d = ctrl_q;
            endcase
        end
        ev = 8'h00;
        ev[`TC_FLG_OVF] = ovf_hit;
        ev[`TC_FLG_CMP] = cmp_hit;
        // a new event wins over the read that clears the flags
        flags_d = (rd_flag ? 8'h00 : flags_q) | ev;
        irq_d = |(flags_d & mask_d);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= `TC_RST_BYTE;
            cnt_q <= `TC_RST_BYTE;
            buf_q <= `TC_RST_BYTE;
            act_q <= `TC_RST_BYTE;
            flags_q <= `TC_RST_BYTE;
            mask_q <= `TC_RST_BYTE;
            dir_q <= 1'b1;
            block_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (CE) begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            buf_q <= buf_d;
            act_q <= act_d;
            flags_q <= flags_d;
            mask_q <= mask_d;
            dir_q <= dir_d;
            block_q <= block_d;
            irq_q <= irq_d;
        end
    end

    assign IRQ = irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_stop_hold;
        @(posedge CLK) disable iff (!NRST)
        (cs == tc_pkg::TC_STOP && !cnt_wr) |=> $stable(cnt_q);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

    property p_write_wins;
        @(posedge CLK) disable iff (!NRST)
        (CE && cnt_wr) |=> (cnt_q == $past(wbyte_q));
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("count write lost");

    property p_cmp_flag;
        @(posedge CLK) disable iff (!NRST)
        (tick && cnt_q == act_q && !block_q) |=> flags_q[`TC_FLG_CMP];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("match flag missing");

    property p_block;
        @(posedge CLK) disable iff (!NRST)
        (CE && cnt_wr && !cmp_hit && !flags_q[`TC_FLG_CMP]) ##1 (tick && !cnt_wr)[*1]
        |=> !flags_q[`TC_FLG_CMP];
    endproperty
    a_block: assert property (p_block) else $error("blocked match set flag");

    property p_irq;
        @(posedge CLK) disable iff (!NRST)
        ##1 (IRQ == |(flags_q & mask_q));
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with flags");

    property p_overflow;
        @(posedge CLK) disable iff (!NRST)
        (tick && !cnt_wr && at_max && mode == tc_pkg::TC_NORMAL)
        |=> (cnt_q == `TC_BOTTOM) && flags_q[`TC_FLG_OVF];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow wrong");

    property p_ctc_top;
        @(posedge CLK) disable iff (!NRST)
        (tick && !cnt_wr && cnt_q == act_q && mode == tc_pkg::TC_CTC)
        |=> (cnt_q == `TC_BOTTOM);
    endproperty
    a_ctc_top: assert property (p_ctc_top) else $error("ctc did not clear");

    property p_down;
        @(posedge CLK) disable iff (!NRST)
        (tick && !cnt_wr && !dir_q && !at_bottom && mode == tc_pkg::TC_PHASE_PWM)
        |=> (cnt_q == $past(cnt_q) - 8'h01);
    endproperty
    a_down: assert property (p_down) else $error("down count wrong");

    property p_flag_read;
        @(posedge CLK) disable iff (!NRST)
        (rd_flag && !tick && CE) |=> (flags_q == 8'h00);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("read did not clear");

    c_ovf: cover property (@(posedge CLK) disable iff (!NRST) ovf_hit);
    c_cmp: cover property (@(posedge CLK) disable iff (!NRST) cmp_hit ##1 IRQ);
    c_turn: cover property (@(posedge CLK) disable iff (!NRST) tick && at_max && !dir_d);
    c_blocked: cover property (@(posedge CLK) disable iff (!NRST)
        tick && block_q && cnt_q == act_q);
endmodule

// [tc_consts.svh]
// constants of the 8-bit timer/counter: offsets, fields, reset values, timing
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define TC_ADDR_W 8
`define TC_CTRL_OFS 8'h00
`define TC_COUNT_OFS 8'h04
`define TC_COMPARE_OFS 8'h08
`define TC_FLAG_OFS 8'h0C
`define TC_MASK_OFS 8'h10

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define TC_CS_HI 2
`define TC_CS_LO 0
`define TC_MODE_HI 4
`define TC_MODE_LO 3
`define TC_OUT_HI 6
`define TC_OUT_LO 5
`define TC_FORCE_BIT 7
`define TC_CTRL_RMASK 8'h7F
`define TC_FLG_OVF 0
`define TC_FLG_CMP 1
`define TC_FLG_MASK 8'h03
`define TC_RST_BYTE 8'h00
`define TC_MAX 8'hFF
`define TC_BOTTOM 8'h00
`define TC_RESP_OKAY 2'h0
`define TC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// prescaler taps (divide by 8, 64, 256, 1024)
// ----------------------------------------------------------------
`define TC_PRE_W 10
`define TC_PRE_8 10'h007
`define TC_PRE_64 10'h03F
`define TC_PRE_256 10'h0FF
`define TC_PRE_1024 10'h3FF

`endif

// [tc_pkg.sv]
// types shared by the timer/counter modules
package tc_pkg;
    typedef enum logic [1:0] {
        TC_NORMAL,
        TC_PHASE_PWM,
        TC_CTC,
        TC_FAST_PWM
    } tc_mode_t;
    typedef enum logic [2:0] {
        TC_STOP, TC_DIV1, TC_DIV8, TC_DIV64,
        TC_DIV256, TC_DIV1024, TC_EXT_FALL, TC_EXT_RISE
    } tc_cs_t;
endpackage

// [tc_clksel.sv]
// clock select: prescaler, external pin synchroniser and edge detect, tick
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_clksel (
    input logic clk,
    input logic nrst,
    input logic ce,
    input tc_pkg::tc_cs_t cs,
    input logic ext_pin,
    output logic tick
);
    logic [`TC_PRE_W-1:0] pre_q, pre_d;
    logic s1_q, s2_q, s3_q;

    // ----------------------------------------------------------------
    // prescaler runs free so the tap phase does not depend on selection
    // ----------------------------------------------------------------
    always_comb begin
        pre_d = pre_q + 10'h001;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= '0;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            pre_q <= pre_d;
            s1_q <= ext_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ----------------------------------------------------------------
    // tick selection: source and active edge
    // ----------------------------------------------------------------
    always_comb begin
        case (cs)
            tc_pkg::TC_STOP: tick = 1'b0;
            tc_pkg::TC_DIV1: tick = ce;
            tc_pkg::TC_DIV8: tick = ce && ((pre_q & `TC_PRE_8) == `TC_PRE_8);
            tc_pkg::TC_DIV64: tick = ce && ((pre_q & `TC_PRE_64) == `TC_PRE_64);
            tc_pkg::TC_DIV256: tick = ce && ((pre_q & `TC_PRE_256) == `TC_PRE_256);
            tc_pkg::TC_DIV1024: tick = ce && (pre_q == `TC_PRE_1024);
            tc_pkg::TC_EXT_FALL: tick = ce && s3_q && !s2_q;
            tc_pkg::TC_EXT_RISE: tick = ce && !s3_q && s2_q;
            default: tick = 1'b0;
        endcase
    end
endmodule

// [tc_wavegen.sv]
// waveform generator: drives the compare output from match, force and the wrap at top
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_wavegen (
    input logic clk,
    input logic nrst,
    input logic ce,
    input tc_pkg::tc_mode_t mode,
    input logic [1:0] out_mode,
    input logic match,
    input logic wrap,
    input logic dir_up,
    input logic force_cmp,
    output logic oc_q
);
    logic oc_d;

    // ----------------------------------------------------------------
    // output state; out_mode zero leaves the state alone in every mode
    // ----------------------------------------------------------------
    always_comb begin
        oc_d = oc_q;
        case (mode)
            tc_pkg::TC_NORMAL, tc_pkg::TC_CTC: begin
                // force acts like a match but raises no flag
                if (match || force_cmp) begin
                    case (out_mode)
                        2'h1: oc_d = !oc_q;
                        2'h2: oc_d = 1'b0;
                        2'h3: oc_d = 1'b1;
                        default: oc_d = oc_q;
                    endcase
                end
            end
            tc_pkg::TC_FAST_PWM: begin
                if (out_mode[1] && match) begin
                    oc_d = out_mode[0];
                end else if (out_mode[1] && wrap) begin
                    oc_d = !out_mode[0];
                end
            end
            tc_pkg::TC_PHASE_PWM: begin
                if (out_mode[1] && match) begin
                    oc_d = dir_up ? out_mode[0] : !out_mode[0];
                end
            end
            default: oc_d = oc_q;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oc_q <= 1'b0;
        end else if (ce) begin
            oc_q <= oc_d;
        end
    end
endmodule

// [tc_cpu_model.sv]
// register bus master standing in for the cpu core
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_cpu_model (
    input logic clk,
    output logic [`TC_ADDR_W-1:0] awaddr,
    output logic awvalid,
    input logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input logic wready,
    input logic [1:0] bresp,
    input logic bvalid,
    output logic bready,
    output logic [`TC_ADDR_W-1:0] araddr,
    output logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic [1:0] rresp,
    input logic rvalid,
    output logic rready,
    output logic hung
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
    end
    // --------------------------------
    // write: address and data offered together, each dropped once taken
    // --------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        r = bresp;
        hung <= (n == 100);
        bready <= 1'h0;
        // one idle edge so the next request never lands in the same step
        @(posedge clk);
    endtask
    // --------------------------------
    // read
    // --------------------------------
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        v = rdata;
        r = rresp;
        hung <= (n == 100);
        rready <= 1'h0;
        @(posedge clk);
    endtask
endmodule

// [tc_timer_tb.sv]
// self-checking testbench of the 8-bit timer/counter
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_timer_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } tc_row_t;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic ext = 1'h0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cmp_out, irq, hung;
    int mismatches = 0;
    int samples_checked = 0;
    int i;
    tc_row_t rows [9] = '{
        '{`TC_CTRL_OFS, 32'h18, 32'h18, `TC_RESP_OKAY},
        '{`TC_CTRL_OFS, 32'h00, 32'h00, `TC_RESP_OKAY},
        '{`TC_COUNT_OFS, 32'h5A, 32'h5A, `TC_RESP_OKAY},
        '{`TC_COUNT_OFS, 32'h1A5, 32'hA5, `TC_RESP_OKAY},
        '{`TC_COMPARE_OFS, 32'hC3, 32'hC3, `TC_RESP_OKAY},
        '{`TC_MASK_OFS, 32'h03, 32'h03, `TC_RESP_OKAY},
        '{`TC_MASK_OFS, 32'h00, 32'h00, `TC_RESP_OKAY},
        '{`TC_FLAG_OFS, 32'h03, 32'h00, `TC_RESP_OKAY},
        '{8'h14, 32'hFF, 32'h00, `TC_RESP_SLVERR}
    };

    tc_timer i_dut (
        .CLK(clk), .NRST(nrst), .CE(1'h1), .EXT_COUNT_IN(ext),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .COMPARE_OUT(cmp_out), .IRQ(irq)
    );
    tc_cpu_model i_cpu (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung)
    );

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (hung) begin
            mismatches++;
            complete_run();
        end
    end

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] v);
        i_cpu.wr(a, v, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        i_cpu.rd(a, d, r);
        chk(d, e);
    endtask
    task automatic complete_run();
        $display("samples_checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        for (i = 0; i < 5; i++) rc(8'(i * 4), 32'h0);
        foreach (rows[k]) begin
            i_cpu.wr(rows[k].a, rows[k].d, r);
            chk(32'(r), 32'(rows[k].r));
            repeat (10) @(posedge clk);
            i_cpu.rd(rows[k].a, d, r);
            chk(d, rows[k].e);
            chk(32'(r), 32'(rows[k].r));
        end
        // full rate run across the compare value and the wrap
        w(`TC_COUNT_OFS, 32'hF0);
        w(`TC_COMPARE_OFS, 32'hF8);
        w(`TC_CTRL_OFS, 32'(tc_pkg::TC_DIV1));
        repeat (40) @(posedge clk);
        w(`TC_CTRL_OFS, 32'h0);
        chk(32'(irq), 32'h0);
        w(`TC_MASK_OFS, 32'h2);
        chk(32'(irq), 32'h1);
        rc(`TC_FLAG_OFS, 32'h3);
        chk(32'(irq), 32'h0);
        rc(`TC_FLAG_OFS, 32'h0);
        // a count write while stopped keeps its block until the first tick
        w(`TC_COMPARE_OFS, 32'h20);
        w(`TC_COUNT_OFS, 32'h20);
        w(`TC_CTRL_OFS, 32'(tc_pkg::TC_DIV1));
        repeat (20) @(posedge clk);
        w(`TC_COUNT_OFS, 32'h20);
        repeat (4) @(posedge clk);
        w(`TC_CTRL_OFS, 32'h0);
        rc(`TC_FLAG_OFS, 32'h0);
        // clear on compare: count must never pass the compare value
        w(`TC_COMPARE_OFS, 32'h05);
        w(`TC_COUNT_OFS, 32'h00);
        w(`TC_CTRL_OFS, 32'h11);
        repeat (30) @(posedge clk);
        chk(32'(irq), 32'h1);
        w(`TC_CTRL_OFS, 32'h10);
        i_cpu.rd(`TC_COUNT_OFS, d, r);
        chk(32'(d <= 32'h5), 32'h1);
        rc(`TC_FLAG_OFS, 32'h2);
        // pin counting on falling then rising edges, five pulses each
        for (i = 6; i < 8; i++) begin
            w(`TC_COUNT_OFS, 32'h0);
            w(`TC_CTRL_OFS, 32'(i));
            repeat (5) begin
                ext <= 1'h1;
                repeat (4) @(posedge clk);
                ext <= 1'h0;
                repeat (4) @(posedge clk);
            end
            repeat (4) @(posedge clk);
            w(`TC_CTRL_OFS, 32'h0);
            rc(`TC_COUNT_OFS, 32'h5);
        end
        rc(`TC_FLAG_OFS, 32'h0);
        // forced compare with toggle action, twice; the strobe uses the held output mode
        w(`TC_CTRL_OFS, 32'h20);
        w(`TC_CTRL_OFS, 32'hA0);
        chk(32'(cmp_out), 32'h1);
        rc(`TC_CTRL_OFS, 32'h20);
        w(`TC_CTRL_OFS, 32'hA0);
        chk(32'(cmp_out), 32'h0);
        rc(`TC_FLAG_OFS, 32'h0);
        // phase correct: turns at the top, sets on the down match, overflows at bottom
        w(`TC_COMPARE_OFS, 32'h80);
        w(`TC_COUNT_OFS, 32'hFA);
        w(`TC_CTRL_OFS, 32'h49);
        repeat (300) @(posedge clk);
        w(`TC_CTRL_OFS, 32'h0);
        chk(32'(cmp_out), 32'h1);
        rc(`TC_FLAG_OFS, 32'h3);
        // fast pwm: clears on the match, sets again at the wrap
        w(`TC_COUNT_OFS, 32'h70);
        w(`TC_CTRL_OFS, 32'h59);
        repeat (60) @(posedge clk);
        chk(32'(cmp_out), 32'h0);
        repeat (150) @(posedge clk);
        w(`TC_CTRL_OFS, 32'h0);
        chk(32'(cmp_out), 32'h1);
        rc(`TC_FLAG_OFS, 32'h3);
        // reset in mid-run
        w(`TC_CTRL_OFS, 32'hA0);
        w(`TC_MASK_OFS, 32'h3);
        w(`TC_CTRL_OFS, 32'h01);
        repeat (300) @(posedge clk);
        chk(32'(irq), 32'h1);
        nrst <= 1'h0;
        @(posedge clk);
        chk(32'({irq, cmp_out}), 32'h0);
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        for (i = 0; i < 5; i++) rc(8'(i * 4), 32'h0);
        complete_run();
    end
endmodule
